// [design/search_accel_config.sv]
// search accelerator, host byte handling and configuration parameter store
//
// Overview of operation
// - each byte covers four positions: even bits filler, odd bits preferred path
// - each position gets first read, second read, then write slot
// - write value: path on conflict, first read otherwise, one on no response
// - sixteen reply bytes; even bit discrepancy, odd bit chosen path
// - discrepancy set on conflict or no response, else cleared
// - chosen path reported equals the value written in third slot
// - after bus error every later path bit is one until accelerator off
// - host resets bus, sends search command in data mode, gets echo
// - mode switches and accelerator command silent; bus reset answers status
// - power-up or master reset loads default configuration
// - parameters addressed by 3-bit code, value by 3-bit code
// - programming pulse and strong pullup durations, usable at all speeds
// - host baud-rate parameter, code 111, default lowest rate
// - slew-rate parameter applied only at flexible speed
// - write-1 low time parameter, overdrive uses short default
// - one parameter sets sample delay and write-0 recovery
// - flexible speed with defaults equals standard waveforms
// - accelerated data byte becomes twelve slots, three per position
// - accelerator command carries flag in bit 4, immediate, silent
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
module search_accel_config
    import search_accel_pkg::*;
(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        HOST_VALID,
    input  wire logic [7:0]  HOST_DATA,
    output logic             HOST_READY,
    output logic             RESP_VALID,
    output logic      [7:0]  RESP_DATA,
    output logic             SLOT_REQ,
    output slot_kind_t       SLOT_KIND,
    input  wire logic        SLOT_DONE,
    input  wire logic [1:0]  SLOT_RESULT,
    output logic             ACCEL_ON,
    output logic             DATA_MODE,
    output speed_t           SPEED,
    output timing_t          TIMING
);
    function automatic logic [2:0] field(input logic [23:0] v, input logic [2:0] c);
        field = v[3*c +: 3];
    endfunction : field

    state_t      state_r, state_nxt;
    job_t        job_r;
    logic [1:0]  sub_r;
    logic [2:0]  pos_r;
    logic        rd_first_r, rd_second_r, err_r;
    logic [7:0]  path_r, resp_r;
    logic [23:0] params_r;
    logic [3:0]  byte_cnt_r, slot_cnt_r;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire take      = HOST_VALID && HOST_READY;
    wire is_dmode  = HOST_DATA == CMD_DATA_MODE;
    wire is_cmode  = HOST_DATA == CMD_CMD_MODE;
    wire is_accel  = (HOST_DATA & CMD_CLS_MASK) == CMD_ACCEL;
    wire is_breset = (HOST_DATA & CMD_CLS_MASK) == CMD_BUS_RESET;
    wire is_cfg    = !HOST_DATA[7] && HOST_DATA[0];
    wire cfg_read  = HOST_DATA[6:4] == 3'h0;
    wire apb_acc   = PSEL && PENABLE && !PREADY;
    // a write lands only at the completing edge, where the master sees pready high
    wire apb_done  = PSEL && PENABLE && PREADY;
    wire apb_wr    = apb_done && PWRITE;
    wire mrst      = RST || (apb_wr && PADDR == ADDR_CTRL && PWDATA[CTRL_MRST]);
    wire conflict  = !rd_first_r && !rd_second_r;
    wire no_resp   = rd_first_r && rd_second_r;
    // after a bus error the written bit stays one, so the reported path matches it
    wire wr_val    = err_r || (conflict ? path_r[{pos_r[1:0], 1'b1}] : (no_resp | rd_first_r));
    wire last_pos  = (job_r == JOB_ACCEL) ? pos_r == 3'h3 : pos_r == 3'h7;
    wire cmd_take  = take && !DATA_MODE;
    wire start_job = take && ((DATA_MODE && !is_cmode) || (!DATA_MODE && is_breset));
    wire imm_reply = cmd_take && is_cfg;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE:  if (start_job) state_nxt = ST_ISSUE;
                      else if (imm_reply) state_nxt = ST_REPLY;
            ST_ISSUE: state_nxt = ST_WAIT;
            ST_WAIT:  if (SLOT_DONE) state_nxt = (job_r == JOB_RESET || (last_pos && sub_r == 2'h2) ||
                                                  (job_r == JOB_BYTE && last_pos)) ? ST_REPLY : ST_ISSUE;
            ST_REPLY: state_nxt = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            state_r    <= ST_IDLE;
            job_r      <= JOB_BYTE;
            sub_r      <= 2'h0;
            pos_r      <= 3'h0;
            rd_first_r  <= 1'b0;
            rd_second_r <= 1'b0;
            path_r     <= 8'h00;
            resp_r     <= 8'h00;
            slot_cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE && take) begin
                path_r     <= HOST_DATA;
                sub_r      <= 2'h0;
                pos_r      <= 3'h0;
                slot_cnt_r <= 4'h0;
                job_r      <= !DATA_MODE ? JOB_RESET : (ACCEL_ON ? JOB_ACCEL : JOB_BYTE);
                if (imm_reply) begin
                    // read answers the stored code, write echoes; bit 0 always clear
                    resp_r <= cfg_read ? {HOST_DATA[7:4], field(params_r, HOST_DATA[3:1]), 1'b0}
                                       : {HOST_DATA[7:1], 1'b0};
                end
            end
            if (state_r == ST_WAIT && SLOT_DONE) begin
                slot_cnt_r <= slot_cnt_r + 4'h1;
                unique case (job_r)
                    JOB_ACCEL: begin
                        if (sub_r == 2'h0) rd_first_r <= SLOT_RESULT[0];
                        if (sub_r == 2'h1) rd_second_r <= SLOT_RESULT[0];
                        sub_r <= (sub_r == 2'h2) ? 2'h0 : sub_r + 2'h1;
                        if (sub_r == 2'h2) begin
                            resp_r[{pos_r[1:0], 1'b0}] <= conflict || no_resp;
                            resp_r[{pos_r[1:0], 1'b1}] <= err_r || wr_val;
                            pos_r <= pos_r + 3'h1;
                        end
                    end
                    JOB_BYTE: begin
                        resp_r[pos_r] <= SLOT_RESULT[0];
                        pos_r         <= pos_r + 3'h1;
                    end
                    JOB_RESET: resp_r <= {RST_ANS_TOP, SLOT_RESULT};
                    default: resp_r <= resp_r;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // mode, accelerator flag and parameter store
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (mrst) begin
            params_r   <= PARAM_DEFAULTS;
            ACCEL_ON   <= 1'b0;
            DATA_MODE  <= 1'b0;
            SPEED      <= SPD_STD;
            err_r      <= 1'b0;
            byte_cnt_r <= 4'h0;
        end else begin
            if (take && DATA_MODE && is_cmode) DATA_MODE <= 1'b0;
            if (cmd_take && is_dmode) DATA_MODE <= 1'b1;
            if (cmd_take && is_accel && !is_dmode) begin
                ACCEL_ON <= HOST_DATA[ACCEL_FLAG];
                SPEED    <= speed_t'(HOST_DATA[3:2]);
                if (!HOST_DATA[ACCEL_FLAG]) err_r <= 1'b0;
                byte_cnt_r <= 4'h0;
            end
            if (cmd_take && is_breset && !is_dmode && !is_cmode) SPEED <= speed_t'(HOST_DATA[3:2]);
            if (state_r == ST_WAIT && SLOT_DONE && job_r == JOB_ACCEL && sub_r == 2'h2 && no_resp)
                err_r <= 1'b1;
            if (state_r == ST_REPLY && job_r == JOB_ACCEL) byte_cnt_r <= byte_cnt_r + 4'h1;
            if (imm_reply && !cfg_read) params_r[3*HOST_DATA[6:4] +: 3] <= HOST_DATA[3:1];
            else if (apb_wr && PADDR == ADDR_PARAM) params_r <= PWDATA[23:0];
        end
    end

    // ------------------------------------------------------------
    // outputs to host and slot generator
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            HOST_READY <= 1'b0;
            RESP_VALID <= 1'b0;
            RESP_DATA  <= 8'h00;
            SLOT_REQ   <= 1'b0;
            SLOT_KIND  <= SK_READ;
        end else begin
            HOST_READY <= state_nxt == ST_IDLE && !(state_r == ST_IDLE && take);
            RESP_VALID <= state_r == ST_REPLY;
            if (state_r == ST_REPLY) RESP_DATA <= resp_r;
            SLOT_REQ <= state_r == ST_ISSUE;
            if (state_r == ST_ISSUE) begin
                unique case (job_r)
                    JOB_ACCEL: SLOT_KIND <= (sub_r != 2'h2) ? SK_READ : (wr_val ? SK_W1 : SK_W0);
                    // a one bit goes out as a read slot so the echo shows the bus
                    JOB_BYTE:  SLOT_KIND <= path_r[pos_r] ? SK_READ : SK_W0;
                    default:   SLOT_KIND <= SK_RESET;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // effective waveform settings
    // ------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            TIMING <= '0;
        end else begin
            TIMING.overdrive <= SPEED == SPD_OD;
            TIMING.prog_pulse  <= field(params_r, PAR_PROG_PULSE);
            TIMING.pullup_time <= field(params_r, PAR_PULLUP_TIME);
            TIMING.baud        <= field(params_r, PAR_BAUD);
            TIMING.slew       <= (SPEED == SPD_FLEX) ? field(params_r, PAR_SLEW) : VAL_DFLT;
            TIMING.w1_low     <= (SPEED == SPD_FLEX) ? field(params_r, PAR_W1_LOW) : VAL_DFLT;
            TIMING.sample_dly <= (SPEED == SPD_FLEX) ? field(params_r, PAR_SAMPLE_DLY) : VAL_DFLT;
        end
    end

    // ------------------------------------------------------------
    // apb slave, two-cycle access, unmapped answers error
    // ------------------------------------------------------------
    wire mapped = PADDR == ADDR_CTRL || PADDR == ADDR_STATUS || PADDR == ADDR_PARAM;
    wire [31:0] rd_mux = (PADDR == ADDR_STATUS) ? {20'h0, byte_cnt_r, err_r, SPEED, DATA_MODE, ACCEL_ON,
                                                   state_r != ST_IDLE, 2'h0} :
                         (PADDR == ADDR_PARAM) ? {8'h0, params_r} : 32'h0;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else begin
            PREADY  <= apb_acc;
            PSLVERR <= apb_acc && !mapped;
            PRDATA  <= (apb_acc && !PWRITE) ? rd_mux : 32'h0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence s_write_issue;
        state_r == ST_ISSUE && job_r == JOB_ACCEL && sub_r == 2'h2;
    endsequence

    AST_REPLY_AFTER_TWELVE: assert property (RESP_VALID && $past(job_r) == JOB_ACCEL
                                             |-> slot_cnt_r == ACCEL_SLOTS)
        else $error("accelerated reply before twelve slots");
    AST_READ_SLOTS: assert property (state_r == ST_ISSUE && job_r == JOB_ACCEL && sub_r != 2'h2
                                     |=> SLOT_REQ && SLOT_KIND == SK_READ)
        else $error("first two slots not read");
    AST_WRITE_CHOICE: assert property (s_write_issue and (conflict)
                                       |=> SLOT_KIND == ((err_r || path_r[{pos_r[1:0],1'b1}]) ? SK_W1 : SK_W0))
        else $error("conflict write not host path");
    AST_NO_RESP_ONE: assert property (s_write_issue and (no_resp) |=> SLOT_KIND == SK_W1)
        else $error("no response must write one");
    AST_ERR_WRITE_ONE: assert property (s_write_issue and (err_r) |=> SLOT_KIND == SK_W1)
        else $error("write after bus error not one");
    AST_DISC_FLAG: assert property (state_r == ST_WAIT && SLOT_DONE && job_r == JOB_ACCEL && sub_r == 2'h2
                                    |=> resp_r[{$past(pos_r[1:0]),1'b0}] == ($past(conflict) || $past(no_resp)))
        else $error("discrepancy flag wrong");
    AST_ERR_FORCE: assert property (err_r && state_r == ST_WAIT && SLOT_DONE && job_r == JOB_ACCEL && sub_r == 2'h2
                                    |=> resp_r[{$past(pos_r[1:0]),1'b1}])
        else $error("path bit not forced after error");
    AST_SILENT_CMDS: assert property (cmd_take && (is_dmode || is_accel) |=> !RESP_VALID [*3])
        else $error("silent command produced reply");
    AST_RESET_KIND: assert property (state_r == ST_ISSUE && job_r == JOB_RESET |=> SLOT_KIND == SK_RESET)
        else $error("bus reset slot kind wrong");
    AST_PLAIN_KIND: assert property (state_r == ST_ISSUE && job_r == JOB_BYTE
                                     |=> SLOT_KIND == (path_r[pos_r] ? SK_READ : SK_W0))
        else $error("plain byte slot kind wrong");
    AST_CFG_REPLY: assert property (imm_reply |-> ##2 RESP_VALID)
        else $error("configuration reply missing");
    AST_ACCEL_FLAG: assert property (cmd_take && is_accel && !is_dmode
                                     |=> ACCEL_ON == $past(HOST_DATA[ACCEL_FLAG]))
        else $error("accelerator flag not taken");
    AST_DEFAULTS: assert property ($past(mrst) && !$past(RST) |-> params_r == PARAM_DEFAULTS && !ACCEL_ON)
        else $error("defaults not loaded");
    AST_FLEX_ONLY: assert property (SPEED != SPD_FLEX && $stable(SPEED) |=> TIMING.slew == VAL_DFLT)
        else $error("slew shaping outside flexible speed");
endmodule : search_accel_config

// [design/search_accel_pkg.sv]
// constants, types and encodings shared by the search accelerator block
package search_accel_pkg;
    // apb register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PARAM  = 8'h08;
    localparam int         CTRL_MRST   = 0;
    // host command bytes and match masks
    localparam logic [7:0] CMD_DATA_MODE = 8'he1;
    localparam logic [7:0] CMD_CMD_MODE  = 8'he3;
    localparam logic [7:0] CMD_CLS_MASK  = 8'he1;
    localparam logic [7:0] CMD_ACCEL     = 8'ha1;
    localparam logic [7:0] CMD_BUS_RESET = 8'hc1;
    localparam int         ACCEL_FLAG    = 4;
    localparam logic [5:0] RST_ANS_TOP   = 6'h33;
    localparam logic [7:0] PATH_BITS     = 8'haa;
    // parameter codes and power-up value codes, three bits per code
    localparam logic [2:0] PAR_SLEW = 3'h1;
    localparam logic [2:0] PAR_PROG_PULSE  = 3'h2;
    localparam logic [2:0] PAR_PULLUP_TIME = 3'h3;
    localparam logic [2:0] PAR_W1_LOW      = 3'h4;
    localparam logic [2:0] PAR_SAMPLE_DLY  = 3'h5;
    localparam logic [2:0] PAR_BAUD = 3'h7;
    localparam logic [2:0] VAL_DFLT = 3'h0;
    localparam logic [23:0] PARAM_DEFAULTS = 24'h000900;
    localparam logic [3:0] ACCEL_SLOTS = 4'hc;

    typedef enum logic [1:0] {SPD_STD = 2'b00, SPD_FLEX = 2'b01, SPD_OD = 2'b10, SPD_STD2 = 2'b11} speed_t;
    typedef enum logic [1:0] {SK_READ = 2'b00, SK_W0 = 2'b01, SK_W1 = 2'b10, SK_RESET = 2'b11} slot_kind_t;
    typedef enum logic [1:0] {JOB_ACCEL = 2'b00, JOB_BYTE = 2'b01, JOB_RESET = 2'b10} job_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10, ST_REPLY = 2'b11} state_t;

    // effective waveform settings handed to the pulse generator
    typedef struct packed {
        logic       overdrive;
        logic [2:0] slew;
        logic [2:0] prog_pulse;
        logic [2:0] pullup_time;
        logic [2:0] w1_low;
        logic [2:0] sample_dly;
        logic [2:0] baud;
    } timing_t;
endpackage : search_accel_pkg

// [tb/slot_dev_model.sv]
// bus device model: answers search read slots from a table of read pairs
`timescale 1ns/1ps
module slot_dev_model
    import search_accel_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         slot_req,
    input  wire slot_kind_t   slot_kind,
    input  wire logic [127:0] pairs,
    input  wire logic         slow,
    input  wire logic         count,
    output logic              slot_done,
    output logic [1:0]        slot_result
);
    int         s_r;
    int         wait_r;
    slot_kind_t kind_r;
    // slot index walks read, read, write per position; a reset slot restarts it
    // pairs table covers positions 0 to 63
    always @(posedge clk) begin
        slot_done   <= 1'b0;
        // result is not held outside a finished slot
        slot_result <= ~slot_result;
        if (rst) begin
            s_r         <= 0;
            wait_r      <= 0;
            kind_r      <= SK_READ;
            slot_result <= 2'b00;
        end else if (slot_req) begin
            wait_r <= slow ? 2 + $urandom_range(0, 9) : 1;
            kind_r <= slot_kind;
        end else if (wait_r == 1) begin
            wait_r    <= 0;
            slot_done <= 1'b1;
            if (kind_r == SK_RESET) begin
                slot_result <= 2'b01;
                s_r         <= 0;
            end else if (!count) begin
                // outside a search the bus reads back what was sent
                slot_result <= {1'b0, kind_r != SK_W0};
            end else begin
                slot_result <= {1'b0, (s_r % 3 == 2) ? 1'b1 : pairs[(2 * (s_r / 3) + s_r % 3) % 128]};
                s_r         <= s_r + 1;
            end
        end else if (wait_r > 1) begin
            wait_r <= wait_r - 1;
        end
    end
endmodule : slot_dev_model

// [tb/tb_search_accel_config.sv]
// self-checking bench for the search accelerator and parameter store
`timescale 1ns/1ps
module tb_search_accel_config;
    import search_accel_pkg::*;
    logic         clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, hv = 0, slow = 0, sticky = 0;
    logic [7:0]   paddr = 8'h00, hd = 8'h00, rd;
    logic [31:0]  pwdata = 32'h0, prdata, r;
    logic         pready, pslverr, hrdy, rv, sreq, sdone, accel, dmode;
    logic [1:0]   sres;
    slot_kind_t   skind;
    speed_t       spd;
    timing_t      tmg;
    logic [127:0] pairs = '0;
    logic [63:0]  path = '0;
    int           err_count = 0, comparisons = 0, cyc = 0, nslot = 0;
    logic [7:0]   rq[$];
    slot_kind_t   kq[$];

    always #25 clk = ~clk;

    search_accel_config u_dut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .HOST_VALID(hv), .HOST_DATA(hd), .HOST_READY(hrdy), .RESP_VALID(rv), .RESP_DATA(rd),
        .SLOT_REQ(sreq), .SLOT_KIND(skind), .SLOT_DONE(sdone), .SLOT_RESULT(sres),
        .ACCEL_ON(accel), .DATA_MODE(dmode), .SPEED(spd), .TIMING(tmg));
    slot_dev_model u_dev (.clk(clk), .rst(rst), .slot_req(sreq), .slot_kind(skind), .pairs(pairs),
        .slow(slow), .count(accel), .slot_done(sdone), .slot_result(sres));

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // monitor: replies, slot kinds, slots per byte, run ceiling
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            print_verdict();
        end
        if (sreq) kq.push_back(skind);
        if (sdone) nslot <= nslot + 1;
        if (hv && hrdy) nslot <= 0;
        if (rv) begin
            rq.push_back(rd);
            if (accel && dmode) chk(nslot, 12);
        end
    end

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic e);
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        chk(pslverr, e);
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic send(input logic [7:0] b);
        @(posedge clk);
        hv <= 1'b1;
        hd <= b;
        do @(posedge clk); while (hrdy !== 1'b1);
        hv <= 1'b0;
    endtask : send

    task automatic quiet(input logic [7:0] b);
        send(b);
        repeat (6) @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        chk(rq.size(), 0);
    endtask : quiet

    task automatic reply(output logic [7:0] v);
        while (rq.size() == 0) @(posedge clk);
        v = rq.pop_front();
    endtask : reply

    // one accelerated pass; errpos marks a position where nobody answers
    task automatic pass(input int errpos);
        logic [7:0] v, hb;
        logic       ra, rb, w, d;
        int         m, n;
        m = -1;
        for (int i = 0; i < 64; i++) pairs[2 * i +: 2] = (i == errpos) ? 2'b11 : 2'($urandom_range(0, 2));
        send(CMD_BUS_RESET);
        reply(v);
        chk(v, {RST_ANS_TOP, 2'b01});
        quiet(CMD_DATA_MODE);
        kq.delete();
        for (int k = 0; k < 16; k++) begin
            for (int p = 0; p < 4; p++) hb[2 * p +: 2] = {path[4 * k + p], 1'($urandom)};
            send(hb);
            reply(v);
            for (int p = 0; p < 4; p++) begin
                n  = 4 * k + p;
                ra = pairs[2 * n];
                rb = pairs[2 * n + 1];
                d  = (ra == rb);
                w  = (ra & rb) | sticky ? 1'b1 : (d ? path[n] : ra);
                sticky |= ra & rb;
                if (d) m = n;
                chk(kq.pop_front(), SK_READ);
                chk(kq.pop_front(), SK_READ);
                chk(kq.pop_front(), w ? SK_W1 : SK_W0);
                chk(v[2 * p +: 2], {w, d});
            end
        end
        // last position reporting path and discrepancy both set keeps the path, otherwise take the highest discrepancy
        if (!(v[7] & v[6]) && m >= 0) begin
            path[m] = 1'b1;
            for (int i = m + 1; i < 64; i++) path[i] = 1'b0;
        end
        quiet(CMD_CMD_MODE);
    endtask : pass

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v;
        void'($urandom(98));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        apb(1'b0, ADDR_PARAM, 32'h0, 1'b0);
        chk(r, {8'h00, PARAM_DEFAULTS});
        apb(1'b1, ADDR_PARAM, {8'h00, PARAM_DEFAULTS} | 32'h1020, 1'b0);
        apb(1'b0, ADDR_PARAM, 32'h0, 1'b0);
        chk(r, 32'h1920);
        apb(1'b0, 8'h0c, 32'h0, 1'b1);
        chk(r, 32'h0);
        // baud code written and read back over the host link
        send(8'h73);
        reply(v);
        chk(v, 8'h72);
        send(8'h0f);
        reply(v);
        chk(v, 8'h02);
        apb(1'b0, ADDR_PARAM, 32'h0, 1'b0);
        chk(r, 32'h201920);
        chk(tmg.baud, 3'h1);
        chk(tmg.prog_pulse, 3'h4);
        chk(tmg.pullup_time, 3'h4);
        // search command sent as a plain byte comes back as sent
        quiet(CMD_DATA_MODE);
        chk(dmode, 1'b1);
        send(8'hf0);
        reply(v);
        chk(v, 8'hf0);
        quiet(CMD_CMD_MODE);
        chk(dmode, 1'b0);
        // accelerator goes on at flexible speed, then overdrive, then standard
        quiet(8'hb5);
        chk(accel, 1'b1);
        chk(spd, SPD_FLEX);
        chk(tmg.slew, 3'h4);
        chk(tmg.w1_low, 3'h1);
        quiet(8'hb9);
        chk(tmg.overdrive, 1'b1);
        chk(tmg.w1_low, 3'h0);
        quiet(8'hb1);
        chk(spd, SPD_STD);
        chk(tmg.slew, 3'h0);
        chk(tmg.w1_low, 3'h0);
        // first pass starts from all-zero paths
        pass(-1);
        slow = 1'b1;
        pass(-1);
        slow = 1'b0;
        pass(20);
        pass(-1);
        quiet(CMD_ACCEL);
        chk(accel, 1'b0);
        sticky = 1'b0;
        quiet(8'hb1);
        pass(-1);
        apb(1'b0, ADDR_STATUS, 32'h0, 1'b0);
        chk(r[3], 1'b1);
        chk(r[4], 1'b0);
        chk(r[7], 1'b0);
        apb(1'b1, ADDR_CTRL, 32'h1, 1'b0);
        apb(1'b0, ADDR_PARAM, 32'h0, 1'b0);
        chk(r, {8'h00, PARAM_DEFAULTS});
        chk(accel, 1'b0);
        print_verdict();
    end
endmodule : tb_search_accel_config
